// file: core/ite_defines.vh
// Functional notes
// (RULE1) Samples shift out most significant bit first
// (RULE2) Word length 16, both ends agree
// (RULE3) Data changes on bit clock rising edge
// (RULE4) Left and right words share one line
// (RULE5) Frame sync leads word MSB by one bit
// (RULE6) Frame sync fixed to rising bit clock edge
// (RULE7) Counter reloads, toggles frame sync every 16
// (RULE8) Counter advanced by the outgoing bit clock
// (RULE9) Subframe 16 bits, toggle after subframe completes
// (RULE10) Left while sync low, right while high
// (RULE11) Master clock derived from the same clock
// (RULE12) Codec is slave, never drives clocks
// (RULE13) Data stable at falling bit clock edge
// (RULE14) First left word carries only 15 bits
// (RULE15) Clocks and data run continuously once started
// (RULE16) Reset clears counter, sync low, data low
// (RULE17) Missing sample sends zero word, keeps running
`ifndef ITE_DEFINES_VH
`define ITE_DEFINES_VH

`define ITE_WORD_W 16
`define ITE_FIFO_DEPTH 4
`define ITE_FIFO_PTR_W 2
`define ITE_CNT_W 5
`define ITE_DIV_W 8

`define ITE_CLK_HZ 25000000
`define ITE_BCLK_HZ 384000
`define ITE_BCLK_HALF_CYC (`ITE_CLK_HZ / (2 * `ITE_BCLK_HZ))
`define ITE_MCLK_HZ 24576000
`define ITE_MCLK_HALF_CYC ((`ITE_CLK_HZ / (2 * `ITE_MCLK_HZ)) == 0 ? 1 : (`ITE_CLK_HZ / (2 * `ITE_MCLK_HZ)))

`define ITE_FS_RESET 1'b0
`define ITE_DATA_RESET 1'b0
`define ITE_BCLK_RESET 1'b0
`define ITE_FS_LEFT 1'b0
`define ITE_FS_RIGHT 1'b1

`endif

// file: core/ite_fifo.v
`timescale 1ns/1ps
`default_nettype none
module ite_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter PTR_W = 2
) (
    input wire clock,
    input wire rst,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output reg inReady,
    output reg [WIDTH-1:0] outData,
    output reg outValid,
    input wire outReady
);
    localparam [PTR_W:0] DEPTH_C = DEPTH[PTR_W:0];
    localparam [PTR_W-1:0] PTR_LAST = DEPTH_C[PTR_W-1:0] - 1'b1;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wrPtr_q;
    reg [PTR_W-1:0] rdPtr_q;
    reg [PTR_W:0] count_q;
    reg [PTR_W-1:0] wrPtr_d;
    reg [PTR_W-1:0] rdPtr_d;
    reg [PTR_W:0] count_d;
    wire wr;
    wire rd;

    function [PTR_W-1:0] incPtr;
        input [PTR_W-1:0] p;
        begin
            incPtr = (p == PTR_LAST) ? {PTR_W{1'b0}} : p + 1'b1;
        end
    endfunction

    assign wr = inValid & inReady;
    assign rd = outReady & outValid;

    always @* begin
        wrPtr_d = wr ? incPtr(wrPtr_q) : wrPtr_q;
        rdPtr_d = rd ? incPtr(rdPtr_q) : rdPtr_q;
        count_d = count_q;
        if (wr && !rd) begin
            count_d = count_q + 1'b1;
        end else if (rd && !wr) begin
            count_d = count_q - 1'b1;
        end
    end

    // Storage has no reset
    always @(posedge clock) begin
        if (wr) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Head word is presented from a register
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_q <= {PTR_W{1'b0}};
            rdPtr_q <= {PTR_W{1'b0}};
            count_q <= {(PTR_W+1){1'b0}};
            inReady <= 1'b0;
            outValid <= 1'b0;
            outData <= {WIDTH{1'b0}};
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            inReady <= (count_d < DEPTH_C);
            outValid <= (count_d != {(PTR_W+1){1'b0}});
            if (wr && (rdPtr_d == wrPtr_q)) begin
                outData <= inData;
            end else begin
                outData <= mem[rdPtr_d];
            end
        end
    end
endmodule // ite_fifo
`default_nettype wire

// file: core/ite_tx.v
`timescale 1ns/1ps
`default_nettype none
`include "ite_defines.vh"
module ite_tx #(
    parameter WORD_W = `ITE_WORD_W,
    parameter FIFO_DEPTH = `ITE_FIFO_DEPTH,
    parameter FIFO_PTR_W = `ITE_FIFO_PTR_W,
    parameter CNT_W = `ITE_CNT_W,
    parameter DIV_W = `ITE_DIV_W,
    parameter BCLK_HALF_CYC = `ITE_BCLK_HALF_CYC,
    parameter MCLK_HALF_CYC = `ITE_MCLK_HALF_CYC
) (
    input wire clock,
    input wire rst,
    input wire txStart,
    input wire [WORD_W-1:0] sampleLeft,
    input wire [WORD_W-1:0] sampleRight,
    input wire sampleValid,
    output wire sampleReady,
    output reg shiftPortClockPin,
    output reg shiftPortDataOutPin,
    output reg frameSync,
    output reg masterClockPin,
    output reg txRunning,
    output reg underrun
);
    localparam [2:0] S_IDLE = 3'h1;
    localparam [2:0] S_FIRST = 3'h2;
    localparam [2:0] S_RUN = 3'h4;

    localparam [DIV_W-1:0] DIV_LAST = BCLK_HALF_CYC[DIV_W-1:0] - 1'b1;
    localparam [DIV_W-1:0] MDIV_LAST = MCLK_HALF_CYC[DIV_W-1:0] - 1'b1;
    localparam [CNT_W-1:0] POS_LAST = WORD_W[CNT_W-1:0] - 1'b1;
    localparam [CNT_W-1:0] POS_ZERO = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] POS_LOAD = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] POS_FIRST = POS_ZERO - WORD_W[CNT_W-1:0];

    // State
    reg [2:0] state_q;
    reg [2:0] state_d;

    // Bit clock divider
    reg [DIV_W-1:0] divCnt_q;
    reg [DIV_W-1:0] divCnt_d;
    reg bclk_d;
    wire divWrap;
    wire timerExternalClockInput;

    // Master clock divider
    reg [DIV_W-1:0] mdivCnt_q;

    // Frame sync counter and shifter
    reg [CNT_W-1:0] pos_q;
    reg [CNT_W-1:0] pos_d;
    reg fs_d;
    reg [WORD_W-1:0] shift_q;
    reg [WORD_W-1:0] shift_d;
    reg data_d;
    reg [WORD_W-1:0] rightHold_q;
    reg [WORD_W-1:0] rightHold_d;
    reg underrun_d;
    reg pop;
    reg loadFirst;
    reg loadLeft;
    reg loadRight;

    // Sample buffer
    wire [2*WORD_W-1:0] headPair;
    wire headValid;

    function divDone;
        input [DIV_W-1:0] cnt;
        input [DIV_W-1:0] last;
        begin
            divDone = (cnt == last);
        end
    endfunction

    function [CNT_W-1:0] nextPos;
        input [CNT_W-1:0] p;
        begin
            nextPos = (p == POS_LAST) ? POS_ZERO : p + 1'b1;
        end
    endfunction

    function [WORD_W-1:0] shl;
        input [WORD_W-1:0] w;
        begin
            shl = {w[WORD_W-2:0], 1'b0};
        end
    endfunction

    function [WORD_W-1:0] pairLeft;
        input [2*WORD_W-1:0] pair;
        begin
            pairLeft = pair[2*WORD_W-1:WORD_W];
        end
    endfunction

    function [WORD_W-1:0] pairRight;
        input [2*WORD_W-1:0] pair;
        begin
            pairRight = pair[WORD_W-1:0];
        end
    endfunction

    ite_fifo #(
        .WIDTH(2 * WORD_W),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(FIFO_PTR_W)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .inData({sampleLeft, sampleRight}),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .outData(headPair),
        .outValid(headValid),
        .outReady(pop)
    );

    assign divWrap = divDone(divCnt_q, DIV_LAST);

    // Rising edge of the outgoing bit clock drives the sync counter
    assign timerExternalClockInput = divWrap & ~shiftPortClockPin & ~state_q[0]; // RULE8

    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (txStart) begin
                    state_d = S_FIRST;
                end
            end
            S_FIRST: begin
                if (timerExternalClockInput) begin
                    state_d = S_RUN;
                end
            end
            S_RUN: begin
                state_d = S_RUN; // RULE15
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // Bit clock free runs once started
    always @* begin
        divCnt_d = divCnt_q;
        bclk_d = shiftPortClockPin;
        if (state_q[0]) begin
            divCnt_d = {DIV_W{1'b0}};
            bclk_d = `ITE_BCLK_RESET;
        end else if (divWrap) begin
            divCnt_d = {DIV_W{1'b0}};
            bclk_d = ~shiftPortClockPin;
        end else begin
            divCnt_d = divCnt_q + 1'b1;
        end
    end

    // Sync counter advances on each outgoing bit clock rise
    always @* begin
        pos_d = pos_q;
        fs_d = frameSync;
        if (timerExternalClockInput) begin
            case (state_q)
                S_FIRST: begin
                    // First wrap falls one word after the first rise
                    pos_d = POS_FIRST; // RULE14
                end
                S_RUN: begin
                    pos_d = nextPos(pos_q); // RULE7
                    if (pos_d == POS_ZERO) begin
                        fs_d = ~frameSync; // RULE6 RULE7 RULE9
                    end
                end
                default: begin
                    pos_d = pos_q;
                end
            endcase
        end
    end

    // Word boundaries
    always @* begin
        loadFirst = 1'b0;
        loadLeft = 1'b0;
        loadRight = 1'b0;
        if (timerExternalClockInput) begin
            case (state_q)
                S_FIRST: begin
                    loadFirst = 1'b1;
                end
                S_RUN: begin
                    // Word starts one bit after the sync change
                    if (nextPos(pos_q) == POS_LOAD) begin // RULE5
                        if (frameSync == `ITE_FS_LEFT) begin // RULE10
                            loadLeft = 1'b1;
                        end else begin
                            loadRight = 1'b1;
                        end
                    end
                end
                default: begin
                    loadFirst = 1'b0;
                end
            endcase
        end
    end

    // A waiting pair leaves the buffer at each left word start
    always @* begin
        pop = 1'b0;
        underrun_d = 1'b0;
        if (loadFirst || loadLeft) begin
            pop = headValid;
            underrun_d = ~headValid; // RULE17
        end
    end

    // Shifter
    always @* begin
        data_d = shiftPortDataOutPin;
        shift_d = shift_q;
        rightHold_d = rightHold_q;
        if (loadFirst || loadLeft) begin
            if (headValid) begin
                rightHold_d = pairRight(headPair); // RULE4
            end else begin
                rightHold_d = {WORD_W{1'b0}}; // RULE17
            end
        end
        if (loadFirst) begin
            // First left word loses its top bit
            if (headValid) begin
                data_d = headPair[2*WORD_W-2]; // RULE14
                shift_d = shl(shl(pairLeft(headPair))); // RULE14
            end else begin
                data_d = 1'b0; // RULE17
                shift_d = {WORD_W{1'b0}};
            end
        end else if (loadLeft) begin
            if (headValid) begin
                data_d = headPair[2*WORD_W-1]; // RULE1
                shift_d = shl(pairLeft(headPair));
            end else begin
                data_d = 1'b0; // RULE17
                shift_d = {WORD_W{1'b0}};
            end
        end else if (loadRight) begin
            data_d = rightHold_q[WORD_W-1]; // RULE4 RULE10
            shift_d = shl(rightHold_q);
        end else if (timerExternalClockInput && state_q[2]) begin
            data_d = shift_q[WORD_W-1]; // RULE1 RULE2
            shift_d = shl(shift_q);
        end
    end

    // Control and bit clock
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            divCnt_q <= {DIV_W{1'b0}};
            shiftPortClockPin <= `ITE_BCLK_RESET;
            txRunning <= 1'b0;
        end else begin
            state_q <= state_d;
            divCnt_q <= divCnt_d;
            shiftPortClockPin <= bclk_d; // RULE3
            txRunning <= ~state_d[0];
        end
    end

    // Sync counter and sync line
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pos_q <= POS_ZERO; // RULE16
            frameSync <= `ITE_FS_RESET; // RULE16
        end else begin
            pos_q <= pos_d;
            frameSync <= fs_d;
        end
    end

    // Data changes with the bit clock rise, stable at its fall
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            shiftPortDataOutPin <= `ITE_DATA_RESET; // RULE16
            shift_q <= {WORD_W{1'b0}};
            rightHold_q <= {WORD_W{1'b0}};
            underrun <= 1'b0;
        end else begin
            shiftPortDataOutPin <= data_d; // RULE3 RULE13
            shift_q <= shift_d;
            rightHold_q <= rightHold_d;
            underrun <= underrun_d;
        end
    end

    // Master clock from the same source as the bit clock
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            mdivCnt_q <= {DIV_W{1'b0}};
            masterClockPin <= 1'b0;
        end else if (divDone(mdivCnt_q, MDIV_LAST)) begin
            mdivCnt_q <= {DIV_W{1'b0}};
            masterClockPin <= ~masterClockPin; // RULE11
        end else begin
            mdivCnt_q <= mdivCnt_q + 1'b1;
        end
    end
endmodule // ite_tx
`default_nettype wire

// file: test/ite_tx_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ite_tx_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic txStart,
    input wire logic shiftPortClockPin,
    input wire logic shiftPortDataOutPin,
    input wire logic frameSync,
    input wire logic masterClockPin,
    input wire logic txRunning,
    input wire logic underrun
);
    logic bclk_q;
    logic fs_q;
    logic [4:0] bitCnt_q;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Bit clock rises since the last sync toggle
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            bclk_q <= 1'b0;
            fs_q <= 1'b0;
            bitCnt_q <= 5'h1F;
        end else begin
            bclk_q <= shiftPortClockPin;
            fs_q <= frameSync;
            if (frameSync != fs_q) begin
                bitCnt_q <= 5'h00;
            end else if (shiftPortClockPin && !bclk_q) begin
                bitCnt_q <= bitCnt_q + 5'h01;
            end
        end
    end
    AST_DATA_ON_RISE: assert property ($changed(shiftPortDataOutPin)
        |-> shiftPortClockPin && !$past(shiftPortClockPin)) else $error("data moved off rise");
    AST_FS_ON_RISE: assert property ($changed(frameSync)
        |-> shiftPortClockPin && !$past(shiftPortClockPin)) else $error("sync moved off rise");
    AST_FS_EVERY_16: assert property ((frameSync != fs_q) |-> bitCnt_q == 5'h0F)
        else $error("sync toggle spacing");
    AST_FS_NO_STALL: assert property ((txRunning && bitCnt_q != 5'h1F) |-> bitCnt_q <= 5'h0F)
        else $error("sync stalled");
    AST_BCLK_RUNS: assert property (txRunning |-> ##[1:64] $changed(shiftPortClockPin))
        else $error("bit clock stopped");
    AST_START: assert property (txStart && !txRunning |=> txRunning)
        else $error("start not taken");
    AST_IDLE: assert property (!txRunning |-> !shiftPortClockPin && !shiftPortDataOutPin && !frameSync)
        else $error("idle lines not low");
    AST_UNDER_PULSE: assert property (underrun |=> !underrun && !frameSync)
        else $error("underrun not a pulse");
    AST_UNDER_LEFT: assert property (underrun |-> !frameSync)
        else $error("underrun off left word");
    AST_MCLK: assert property (1'b1 |-> ##[1:8] $changed(masterClockPin))
        else $error("master clock stopped");
endmodule // ite_tx_checker
bind ite_tx ite_tx_checker chk (.clock(clock), .rst(rst), .txStart(txStart),
    .shiftPortClockPin(shiftPortClockPin), .shiftPortDataOutPin(shiftPortDataOutPin),
    .frameSync(frameSync), .masterClockPin(masterClockPin), .txRunning(txRunning),
    .underrun(underrun));
`default_nettype wire

// file: test/ite_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module ite_codec_model (
    input wire logic rst,
    input wire logic bitClock,
    input wire logic serialData,
    input wire logic frameSync
);
    logic [15:0] shift_q;
    logic lastFs_q;
    logic [15:0] words [0:15];
    logic chans [0:15];
    int wordCount;
    // Slave: only listens, drives neither clock nor sync
    always @(negedge bitClock or posedge rst) begin
        if (rst) begin
            shift_q <= 16'h0000;
            lastFs_q <= 1'b0;
            wordCount <= 0;
        end else begin
            shift_q <= {shift_q[14:0], serialData};
            lastFs_q <= frameSync;
            if (frameSync != lastFs_q && wordCount < 16) begin
                words[wordCount] <= {shift_q[14:0], serialData};
                chans[wordCount] <= lastFs_q;
                wordCount <= wordCount + 1;
            end
        end
    end
endmodule // ite_codec_model
`default_nettype wire

// file: test/ite_tx_test.sv
`timescale 1ns/1ps
`default_nettype none
module ite_tx_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic txStart = 1'b0;
    logic [15:0] sampleLeft = 16'h0000;
    logic [15:0] sampleRight = 16'h0000;
    logic sampleValid = 1'b0;
    wire ready, bclk, sdata, fs, mclk, running, under;
    int bad_count = 0;
    int n_checks = 0;
    logic sawUnder = 1'b0;
    always #20 clock = ~clock;
    ite_tx #(.BCLK_HALF_CYC(2)) dut (.clock(clock), .rst(rst), .txStart(txStart),
        .sampleLeft(sampleLeft), .sampleRight(sampleRight), .sampleValid(sampleValid),
        .sampleReady(ready), .shiftPortClockPin(bclk), .shiftPortDataOutPin(sdata),
        .frameSync(fs), .masterClockPin(mclk), .txRunning(running), .underrun(under));
    ite_codec_model codec (.rst(rst), .bitClock(bclk), .serialData(sdata), .frameSync(fs));
    always @(posedge clock) if (under === 1'b1) sawUnder <= 1'b1;
    function automatic logic [15:0] leftOf(input int k);
        return 16'hC3A5 + 16'(k) * 16'h1111;
    endfunction
    function automatic logic [15:0] rightOf(input int k);
        return 16'h9A3C - 16'(k) * 16'h0F01;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Offer a pair and hold it until taken; valid stays high
    task automatic push(input int k);
        int n = 0;
        sampleLeft = leftOf(k);
        sampleRight = rightOf(k);
        sampleValid = 1'b1;
        while (ready !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 2000) begin
                bad_count++;
                wrap_up();
            end
        end
        @(posedge clock);
        #1;
    endtask
    task automatic test_reset;
        logic lastMclk;
        chk({12'h000, bclk, sdata, fs, running}, 16'h0000);
        chk(16'(ready), 16'h0001);
        lastMclk = mclk;
        @(posedge clock);
        #1;
        chk(16'(mclk ^ lastMclk), 16'h0001);
        $display("test_reset done");
    endtask
    task automatic test_fill;
        for (int k = 0; k < 4; k++) push(k);
        sampleLeft = leftOf(4);
        sampleRight = rightOf(4);
        repeat (8) begin
            chk({14'h0000, ready, bclk}, 16'h0000);
            @(posedge clock);
            #1;
        end
        $display("test_fill done");
    endtask
    task automatic test_stream;
        logic [15:0] exp;
        int n = 0;
        txStart = 1'b1;
        @(posedge clock);
        #1;
        txStart = 1'b0;
        chk(16'(running), 16'h0001);
        push(4);
        sampleValid = 1'b0;
        while (codec.wordCount < 12 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(16'(codec.wordCount >= 12), 16'h0001);
        for (int i = 0; i < 12; i++) begin
            exp = i[0] ? rightOf(i / 2) : leftOf(i / 2);
            if (i == 0) exp = {exp[13:0], 2'b00};
            if (i >= 10) exp = 16'h0000;
            chk(codec.words[i], exp);
            chk(16'(codec.chans[i]), 16'(i % 2));
        end
        chk(16'(sawUnder), 16'h0001);
        $display("test_stream done");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        @(posedge clock);
        #1;
        test_reset();
        test_fill();
        test_stream();
        wrap_up();
    end
endmodule // ite_tx_test
`default_nettype wire
